// file: fps_pkg.sv
package fps_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int BLANK_NS = 150;
	localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BROWNOUT_MS = 30;
	localparam int BROWNOUT_CYC = BROWNOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BO_W = 22;
	localparam int BLANK_W = 5;
	// Aux over-voltage debounce default (cycles)
	localparam logic [7:0] AUX_DEB_DEF = 8'h04;
	// Oscillator
	localparam int OSC_W = 12;
	localparam logic [OSC_W-1:0] OSC_BASE = 12'h578;
	localparam int HOP_SHIFT = 3;
	localparam int HOP_BITS = 4;
	localparam logic [OSC_W-1:0] OFF_MIN = 12'h078;
	localparam int RAMP_W = 8;
	localparam int RAMP_LSB = 3;
	localparam logic [7:0] LFSR_SEED = 8'hA5;
	localparam logic [7:0] LFSR_TAPS = 8'hB8;
	// Synchronised input bit positions
	localparam int N_IN = 9;
	localparam int IN_VDD_ON = 0;
	localparam int IN_VDD_OFF = 1;
	localparam int IN_VDD_OVP = 2;
	localparam int IN_LINE_LOW = 3;
	localparam int IN_OTP = 4;
	localparam int IN_AUX_OVP = 5;
	localparam int IN_SD_LOW = 6;
	localparam int IN_CS_LIM = 7;
	localparam int IN_CS_PWM = 8;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_STARTUP = 3'h0,
		ST_RUN = 3'h1,
		ST_AUTO_WAIT = 3'h2,
		ST_LATCH_DISCH = 3'h3,
		ST_LATCH_CHARGE = 3'h4
	} fps_state_t;
endpackage : fps_pkg

// file: fps_osc_if.sv
`timescale 1ns/1ps
interface fps_osc_if;
	logic cycle_start;
	logic duty_end;
	logic [fps_pkg::RAMP_W-1:0] ramp;
	modport src (output cycle_start, output duty_end, output ramp);
	modport dst (input cycle_start, input duty_end, input ramp);
endinterface : fps_osc_if

// file: fps_sync.sv
`timescale 1ns/1ps
module fps_sync (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [fps_pkg::N_IN-1:0] i_async,
	output logic [fps_pkg::N_IN-1:0] o_sync
);
	import fps_pkg::*;
	genvar g;
	generate
		for (g = 0; g < N_IN; g++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic filt_reg;
			// Three stages; value accepted once stages two and three agree
			always_ff @(posedge i_sys_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					filt_reg <= 1'b0;
				end else begin
					s1_reg <= i_async[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						filt_reg <= s3_reg;
					end
				end
			end
			assign o_sync[g] = filt_reg;
		end
	endgenerate
endmodule : fps_sync

// file: fps_hop_osc.sv
`timescale 1ns/1ps
module fps_hop_osc (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	fps_osc_if.src osc
);
	import fps_pkg::*;
	logic [OSC_W-1:0] cnt_reg;
	logic [OSC_W-1:0] period_reg;
	logic [7:0] lfsr_reg;
	logic wrap;
	assign wrap = (cnt_reg == period_reg - 12'h001);
	// Period hops with a pseudo-random offset each cycle
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_reg <= '0;
			period_reg <= OSC_BASE;
			lfsr_reg <= LFSR_SEED;
		end else if (wrap) begin
			cnt_reg <= '0;
			lfsr_reg <= (lfsr_reg >> 1) ^ (lfsr_reg[0] ? LFSR_TAPS : 8'h00);
			period_reg <= OSC_BASE + (OSC_W'(lfsr_reg[HOP_BITS-1:0]) << HOP_SHIFT);
		end else begin
			cnt_reg <= cnt_reg + 12'h001;
		end
	end
	assign osc.cycle_start = (cnt_reg == '0);
	assign osc.duty_end = (cnt_reg == period_reg - OFF_MIN);
	// Rising ramp restarted at each cycle start
	assign osc.ramp = cnt_reg[RAMP_LSB +: RAMP_W];
	a_hop_range: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		wrap |=> (period_reg >= OSC_BASE) && (cnt_reg == '0))
		else $error("hop period out of range");
endmodule : fps_hop_osc

// file: fps_sequencer.sv
`timescale 1ns/1ps
module fps_sequencer #(
	parameter int BO_CYC = fps_pkg::BROWNOUT_CYC,
	parameter logic [7:0] AUX_DEB = fps_pkg::AUX_DEB_DEF
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_vdd_on_cmp,
	input wire logic i_vdd_off_cmp,
	input wire logic i_vdd_ovp_cmp,
	input wire logic i_line_low_cmp,
	input wire logic i_otp_cmp,
	input wire logic i_aux_ovp_cmp,
	input wire logic i_sd_low_cmp,
	input wire logic i_cs_lim_cmp,
	input wire logic i_cs_pwm_cmp,
	output logic o_gate_en,
	output logic o_hv_start_en,
	output logic o_turn_on_blanking,
	output logic [fps_pkg::RAMP_W-1:0] o_slope_ramp,
	output logic o_fault_auto,
	output logic o_fault_latched,
	output fps_pkg::fps_state_t o_state
);
	import fps_pkg::*;

	logic [N_IN-1:0] raw_in;
	logic [N_IN-1:0] syn;
	fps_state_t state_reg;
	fps_state_t state_next;
	logic gate_reg;
	logic gate_next;
	logic hv_reg;
	logic [RAMP_W-1:0] ramp_reg;
	logic [BLANK_W-1:0] blank_cnt_reg;
	logic blank_on;
	logic blank_reg;
	logic [BO_W-1:0] bo_cnt_reg;
	logic [7:0] aux_cnt_reg;
	logic auto_reg;
	logic latch_reg;
	logic vdd_on;
	logic vdd_off;
	logic cs_lim;
	logic cs_pwm;
	logic bo_trip;
	logic aux_trip;
	logic auto_src;
	logic latch_src;
	logic fault_any;
	logic run_now;

	fps_osc_if osc_bus ();

	// Comparator inputs into the clock domain
	assign raw_in = {i_cs_pwm_cmp, i_cs_lim_cmp, i_sd_low_cmp, i_aux_ovp_cmp, i_otp_cmp,
		i_line_low_cmp, i_vdd_ovp_cmp, i_vdd_off_cmp, i_vdd_on_cmp};

	fps_sync u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async(raw_in),
		.o_sync(syn)
	);

	fps_hop_osc u_osc (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.osc(osc_bus.src)
	);

	assign vdd_on = syn[IN_VDD_ON];
	assign vdd_off = syn[IN_VDD_OFF];
	assign cs_lim = syn[IN_CS_LIM];
	assign cs_pwm = syn[IN_CS_PWM];
	assign run_now = (state_reg == ST_RUN);
	assign blank_on = (blank_cnt_reg != '0);

	// Fault sources
	assign bo_trip = run_now && (bo_cnt_reg == BO_W'(BO_CYC - 1)) &&
		!(gate_reg && !syn[IN_LINE_LOW]);
	assign aux_trip = run_now && osc_bus.cycle_start && syn[IN_AUX_OVP] &&
		(aux_cnt_reg == AUX_DEB);
	assign auto_src = run_now && (syn[IN_VDD_OVP] || bo_trip);
	assign latch_src = syn[IN_OTP] || syn[IN_SD_LOW] || aux_trip;
	assign fault_any = auto_src || latch_src || auto_reg || latch_reg;

	// Sequencer over the supply thresholds
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_STARTUP: begin
				if (latch_src || latch_reg) begin
					state_next = ST_LATCH_CHARGE;
				end else if (vdd_on) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (latch_src) begin
					state_next = ST_LATCH_DISCH;
				end else if (auto_src) begin
					state_next = ST_AUTO_WAIT;
				end else if (vdd_off) begin
					state_next = ST_STARTUP;
				end
			end
			ST_AUTO_WAIT: begin
				if (latch_src) begin
					state_next = ST_LATCH_DISCH;
				end else if (vdd_off) begin
					state_next = ST_STARTUP;
				end
			end
			ST_LATCH_DISCH: begin
				if (vdd_off) begin
					state_next = ST_LATCH_CHARGE;
				end
			end
			ST_LATCH_CHARGE: begin
				if (vdd_on) begin
					state_next = ST_LATCH_DISCH;
				end
			end
			default: begin
				state_next = ST_STARTUP;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_STARTUP;
		end else begin
			state_reg <= state_next;
		end
	end

	// Startup source follows the charging states
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hv_reg <= 1'b1;
		end else begin
			hv_reg <= (state_next == ST_STARTUP) || (state_next == ST_LATCH_CHARGE);
		end
	end

	// Auto-restart flag; cleared at the turn-off threshold
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			auto_reg <= 1'b0;
		end else if (auto_src) begin
			auto_reg <= 1'b1;
		end else if (state_reg == ST_AUTO_WAIT && vdd_off) begin
			auto_reg <= 1'b0;
		end
	end

	// Latched flag; only the deep reset clears it
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			latch_reg <= 1'b0;
		end else if (latch_src) begin
			latch_reg <= 1'b1;
		end
	end

	// Brownout timer: cleared by any good on-time line sample
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bo_cnt_reg <= '0;
		end else if (!run_now || (gate_reg && !syn[IN_LINE_LOW]) || bo_trip) begin
			bo_cnt_reg <= '0;
		end else begin
			bo_cnt_reg <= bo_cnt_reg + BO_W'(1);
		end
	end

	// Aux over-voltage debounce per switching cycle
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			aux_cnt_reg <= '0;
		end else if (!run_now) begin
			aux_cnt_reg <= '0;
		end else if (osc_bus.cycle_start) begin
			if (!syn[IN_AUX_OVP]) begin
				aux_cnt_reg <= '0;
			end else if (aux_cnt_reg != AUX_DEB) begin
				aux_cnt_reg <= aux_cnt_reg + 8'h01;
			end
		end
	end

	// Gate drive per switching cycle
	always_comb begin
		gate_next = gate_reg;
		if (fault_any || state_next != ST_RUN) begin
			gate_next = 1'b0;
		end else if (osc_bus.cycle_start) begin
			gate_next = 1'b1;
		end else if (osc_bus.duty_end) begin
			gate_next = 1'b0;
		end else if (!blank_on && (cs_lim || cs_pwm)) begin
			gate_next = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			gate_reg <= 1'b0;
		end else begin
			gate_reg <= gate_next;
		end
	end

	// Blanking window loaded at every turn-on
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			blank_cnt_reg <= '0;
			blank_reg <= 1'b0;
		end else if (gate_next && !gate_reg) begin
			blank_cnt_reg <= BLANK_W'(BLANK_CYC);
			blank_reg <= 1'b1;
		end else if (blank_on) begin
			blank_cnt_reg <= blank_cnt_reg - BLANK_W'(1);
			blank_reg <= (blank_cnt_reg != BLANK_W'(1));
		end
	end

	// Ramp sent to the sense summing node
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ramp_reg <= '0;
		end else begin
			ramp_reg <= osc_bus.ramp;
		end
	end

	// Output flops
	assign o_gate_en = gate_reg;
	assign o_hv_start_en = hv_reg;
	assign o_turn_on_blanking = blank_reg;
	assign o_slope_ramp = ramp_reg;
	assign o_fault_auto = auto_reg;
	assign o_fault_latched = latch_reg;
	assign o_state = state_reg;

	// Checks
	localparam int A_BLANK_LAST = BLANK_CYC - 1;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_turn_on;
		!gate_reg ##1 gate_reg;
	endsequence

	sequence s_latch_recharge;
		(state_reg == ST_LATCH_DISCH) && vdd_off ##1 (state_reg == ST_LATCH_CHARGE);
	endsequence

	a_blank_window: assert property (
		s_turn_on |-> ##A_BLANK_LAST blank_on ##1 !blank_on)
		else $error("blanking window length wrong");

	a_blank_no_cut: assert property (
		gate_reg && blank_on && !fault_any && !osc_bus.duty_end && !osc_bus.cycle_start
		&& (state_next == ST_RUN) |=> gate_reg)
		else $error("gate cut during blanking");

	a_limit_cut: assert property (
		gate_reg && !blank_on && cs_lim |=> !gate_reg)
		else $error("current limit did not end pulse");

	a_fault_gate: assert property (
		fault_any |=> !o_gate_en)
		else $error("gate on with fault active");

	a_startup_hold: assert property (
		(state_reg == ST_STARTUP) && !vdd_on && !latch_src |=>
		(state_reg == ST_STARTUP) && o_hv_start_en && !o_gate_en)
		else $error("startup source or gate wrong");

	a_startup_on: assert property (
		(state_reg == ST_STARTUP) && vdd_on && !latch_src && !latch_reg |=>
		run_now && !o_hv_start_en)
		else $error("turn-on threshold ignored");

	a_auto_clear: assert property (
		(state_reg == ST_AUTO_WAIT) && vdd_off && !latch_src |=>
		(state_reg == ST_STARTUP) && !auto_reg && o_hv_start_en)
		else $error("auto fault not cleared at turn-off");

	a_ovp_auto: assert property (
		run_now && syn[IN_VDD_OVP] && !latch_src |=>
		(state_reg == ST_AUTO_WAIT) && auto_reg && !o_gate_en)
		else $error("supply over-voltage missed");

	a_latch_recharge: assert property (
		s_latch_recharge |-> o_hv_start_en && latch_reg && !o_gate_en)
		else $error("latched recharge wrong");

	a_latch_no_run: assert property (
		(state_reg == ST_LATCH_CHARGE) && vdd_on |=>
		(state_reg == ST_LATCH_DISCH) && !o_hv_start_en && !o_gate_en)
		else $error("latched fault resumed switching");

	a_latch_sticky: assert property (
		latch_reg |=> latch_reg && !o_gate_en)
		else $error("latched fault lost");

	a_aux_trip: assert property (
		run_now && osc_bus.cycle_start && syn[IN_AUX_OVP] && aux_cnt_reg == AUX_DEB
		|=> latch_reg && (state_reg == ST_LATCH_DISCH))
		else $error("aux over-voltage not latched");

	a_aux_reset: assert property (
		run_now && osc_bus.cycle_start && !syn[IN_AUX_OVP] |=> aux_cnt_reg == '0)
		else $error("aux debounce not cleared");

	a_brownout: assert property (
		bo_trip && !latch_src |=> (state_reg == ST_AUTO_WAIT) && auto_reg)
		else $error("brownout not raised");

	a_otp_sd: assert property (
		syn[IN_OTP] || syn[IN_SD_LOW] |=> latch_reg && !o_gate_en)
		else $error("temperature or shutdown not latched");
endmodule : fps_sequencer

// file: fps_switch_model.sv
`timescale 1ns/1ps
module fps_switch_model (
	input wire logic i_sys_clk,
	input wire logic i_gate_en,
	input wire logic i_line_fault,
	input wire logic [7:0] i_lim_dly,
	input wire logic [7:0] i_pwm_dly,
	output logic o_cs_lim_cmp,
	output logic o_cs_pwm_cmp,
	output logic o_line_low_cmp
);
	logic [7:0] on_reg;
	// Switch current ramps while gate on
	always_ff @(posedge i_sys_clk) begin
		if (!i_gate_en) begin
			on_reg <= 8'h00;
		end else if (on_reg != 8'hFF) begin
			on_reg <= on_reg + 8'h01;
		end
	end
	// Sense reads zero with the switch off
	assign o_cs_lim_cmp = i_gate_en && (on_reg >= i_lim_dly);
	assign o_cs_pwm_cmp = i_gate_en && (on_reg >= i_pwm_dly);
	assign o_line_low_cmp = i_line_fault;
endmodule : fps_switch_model

// file: fps_sequencer_tb_top.sv
`timescale 1ns/1ps
module fps_sequencer_tb_top;
	import fps_pkg::*;
	localparam int BO_TB = 4000;
	localparam logic [7:0] DEB_TB = 8'h02;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic vdd_on = 1'b0, vdd_off = 1'b0, vdd_ovp = 1'b0, otp = 1'b0, aux = 1'b0, sd = 1'b0;
	logic line_fault = 1'b0;
	logic [7:0] lim_dly = 8'h28, pwm_dly = 8'h3C;
	logic cs_lim, cs_pwm, line_low, gate, hv, blank, f_auto, f_lat;
	logic [RAMP_W-1:0] ramp;
	fps_state_t state;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #4 i_sys_clk = ~i_sys_clk;
	fps_sequencer #(.BO_CYC(BO_TB), .AUX_DEB(DEB_TB)) i_fps_sequencer (
		.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_vdd_on_cmp(vdd_on),
		.i_vdd_off_cmp(vdd_off), .i_vdd_ovp_cmp(vdd_ovp), .i_line_low_cmp(line_low),
		.i_otp_cmp(otp), .i_aux_ovp_cmp(aux), .i_sd_low_cmp(sd), .i_cs_lim_cmp(cs_lim),
		.i_cs_pwm_cmp(cs_pwm), .o_gate_en(gate), .o_hv_start_en(hv),
		.o_turn_on_blanking(blank), .o_slope_ramp(ramp), .o_fault_auto(f_auto),
		.o_fault_latched(f_lat), .o_state(state));
	fps_switch_model i_fps_switch_model (
		.i_sys_clk(i_sys_clk), .i_gate_en(gate), .i_line_fault(line_fault),
		.i_lim_dly(lim_dly), .i_pwm_dly(pwm_dly), .o_cs_lim_cmp(cs_lim),
		.o_cs_pwm_cmp(cs_pwm), .o_line_low_cmp(line_low));
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : tick
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		samples_checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : check_rng
	task automatic wait_state(input fps_state_t st, input int lim);
		int n;
		n = 0;
		while (state !== st && n < lim) begin
			tick();
			n++;
		end
		check(state, st);
	endtask : wait_state
	task automatic wait_gate(input logic lvl, input int lim);
		int n;
		n = 0;
		while (gate !== lvl && n < lim) begin
			tick();
			n++;
		end
		check(gate, lvl);
	endtask : wait_gate
	task automatic pulse_len(output int w);
		w = 0;
		while (gate === 1'b1 && w < 2000) begin
			tick();
			w++;
		end
	endtask : pulse_len
	task automatic do_reset();
		tick();
		i_rstn = 1'b0;
		{vdd_on, vdd_off, vdd_ovp, otp, aux, sd, line_fault} = 7'h00;
		tick(2);
		i_rstn = 1'b1;
		tick();
		check(gate, 1'b0);
		check(hv, 1'b1);
		check({blank, ramp, f_auto}, 10'h000);
		check(f_lat, 1'b0);
		check(state, ST_STARTUP);
	endtask : do_reset
	task automatic power_up();
		vdd_on = 1'b1;
		wait_state(ST_RUN, 20);
		check(hv, 1'b0);
		wait_gate(1'b1, 1700);
	endtask : power_up
	task automatic t_switching();
		int w;
		int n;
		int per[4];
		do_reset();
		power_up();
		check_rng(ramp, 0, 2);
		pulse_len(w);
		check_rng(w, 40, 50);
		lim_dly = 8'h00;
		pwm_dly = 8'hFF;
		wait_gate(1'b1, 1700);
		check(blank, 1'b1);
		pulse_len(w);
		check_rng(w, 19, 27);
		lim_dly = 8'hFF;
		pwm_dly = 8'h3C;
		wait_gate(1'b1, 1700);
		check_rng(ramp, 0, 2);
		pulse_len(w);
		check_rng(w, 60, 70);
		check_rng(ramp, 5, 12);
		lim_dly = 8'h28;
		wait_gate(1'b1, 1700);
		for (int i = 0; i < 4; i++) begin
			pulse_len(w);
			n = 0;
			while (gate !== 1'b1 && n < 2000) begin
				tick();
				n++;
			end
			per[i] = w + n;
			check_rng(per[i], 1399, 1521);
		end
		check((per[0] == per[1] && per[1] == per[2] && per[2] == per[3]), 1'b0);
		$display("test switching done");
	endtask : t_switching
	task automatic t_auto();
		do_reset();
		power_up();
		vdd_ovp = 1'b1;
		for (int i = 0; i < 2; i++) begin
			wait_state(ST_AUTO_WAIT, 20);
			check(f_auto, 1'b1);
			check(gate, 1'b0);
			tick(1600);
			check(gate, 1'b0);
			if (i == 1) begin
				vdd_ovp = 1'b0;
			end
			vdd_on = 1'b0;
			vdd_off = 1'b1;
			wait_state(ST_STARTUP, 20);
			check({f_auto, hv}, 2'h1);
			vdd_off = 1'b0;
			vdd_on = 1'b1;
			wait_state(ST_RUN, 20);
		end
		wait_gate(1'b1, 1700);
		$display("test auto restart done");
	endtask : t_auto
	task automatic t_brownout();
		do_reset();
		power_up();
		line_fault = 1'b1;
		tick(3950);
		check(f_auto, 1'b0);
		wait_state(ST_AUTO_WAIT, 120);
		check({f_auto, gate}, 2'h2);
		$display("test brownout done");
	endtask : t_brownout
	task automatic t_latched(input int kind);
		int w;
		do_reset();
		power_up();
		if (kind == 0) begin
			otp = 1'b1;
		end else if (kind == 1) begin
			sd = 1'b1;
		end else begin
			for (int i = 0; i < 5; i++) begin
				aux = (i != 2);
				pulse_len(w);
				wait_gate(1'b1, 1700);
			end
			tick(10);
			check(f_lat, 1'b0);
			aux = 1'b1;
		end
		wait_state(ST_LATCH_DISCH, 1700);
		check({f_lat, gate, hv}, 3'h4);
		{otp, sd, aux} = 3'h0;
		for (int i = 0; i < 2; i++) begin
			vdd_on = 1'b0;
			vdd_off = 1'b1;
			wait_state(ST_LATCH_CHARGE, 20);
			check({f_lat, hv}, 2'h3);
			vdd_off = 1'b0;
			vdd_on = 1'b1;
			wait_state(ST_LATCH_DISCH, 20);
			check(hv, 1'b0);
			tick(1600);
			check({f_lat, gate}, 2'h2);
		end
		$display("test latched kind %0d done", kind);
	endtask : t_latched
	initial begin
		t_switching();
		t_auto();
		t_brownout();
		for (int k = 0; k < 3; k++) begin
			t_latched(k);
		end
		do_reset();
		finish_test();
	end
endmodule : fps_sequencer_tb_top
